// ==== dv/elu_line_model.sv ====
// model of the external devices that pull the request lines low
module elu_line_model
  import elu_pkg::*;
(
  // clock
  input wire logic sys_clk_in,
  // command from the bench
  input wire logic [ELU_LINES-1:0] pull_low_in,
  input wire logic slow_in,
  // request lines, pulled up while released
  output logic [ELU_LINES-1:0] req_n_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [ELU_LINES-1:0] stage;
  initial stage = '1;
  initial req_n_out = '1;
  // a slow device answers one cycle later than a prompt one
  always @(posedge sys_clk_in) begin
    stage <= ~pull_low_in;
    req_n_out <= slow_in ? stage : ~pull_low_in;
  end
endmodule : elu_line_model

// ==== dv/tb_external_line_interrupt_unit.sv ====
// self-checking bench for the external line interrupt unit
module tb_external_line_interrupt_unit
  import elu_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 1'b0, rst_n = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic slow = 1'b0, ack, irq;
  logic [ELU_ADR_W-1:0] adr = '0;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = '0, rdat, q;
  logic [5:0] pull = 6'h00, req_n, line_irq, en, pl;
  int n_mismatch = 0, checked = 0, cycles = 0;
  logic [31:0] rv;
  logic [3:0] sel_v = 4'hf;
  logic [31:0] seed = 32'h0000_0003;
  localparam logic [23:0] A_SNS = {ELU_IDX_SENSE, 2'b00};
  localparam logic [23:0] A_EN = {ELU_IDX_ENABLE, 2'b00};
  localparam logic [23:0] A_ST = {ELU_IDX_STATUS, 2'b00};
  localparam logic [23:0] A_EV = {ELU_IDX_EVENT, 2'b00};
  localparam logic [23:0] A_MSK = {ELU_IDX_EVMASK, 2'b00};

  always #10 sys_clk = ~sys_clk;

  elu_top u_dut (.sys_clk_in(sys_clk), .rst_n_in(rst_n), .wb_cyc_in(cyc),
    .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel),
    .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack),
    .line_req_n_in(req_n), .line_irq_out(line_irq), .irq_out(irq));
  elu_line_model u_lines (.sys_clk_in(sys_clk), .pull_low_in(pull),
    .slow_in(slow), .req_n_out(req_n));

  // --------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  // expected per-line cpu requests: flag and enable both set
  function automatic logic [31:0] exp_req(input logic [5:0] f,
                                          input logic [5:0] e);
    return {26'h0, f & e};
  endfunction : exp_req

  task automatic complete_run();
    $display("counts: checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // one classic cycle, held until ack is sampled high
  task automatic bus(input logic w, input logic [23:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    @(posedge sys_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= sel_v;
    do @(posedge sys_clk); while (ack !== 1'b1);
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : bus

  task automatic wr(input logic [23:0] a, input logic [31:0] d);
    bus(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input logic [23:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0, q);
    chk(q, exp);
  endtask : rd

  task automatic drive(input logic [5:0] p);
    pull <= p;
    repeat (4) @(posedge sys_clk);
  endtask : drive

  // hang guard
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      complete_run();
    end
  end

  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial begin
    rst_n <= 1'b0;
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(A_EN, 32'h0);
    rd(A_ST, 32'h0);
    rd(A_SNS, 32'h0);
    rd(24'h0, 32'h0);
    wr(A_EN, 32'hff);
    rd(A_EN, 32'h3f);
    $display("test reset and registers done");
    // random level-mode traffic
    for (int i = 0; i < 8; i++) begin
      rv = rnd();
      en = rv[5:0];
      rv = rnd();
      pl = rv[5:0];
      slow <= seed[7];
      wr(A_EN, {26'h0, en});
      drive(pl);
      chk({26'h0, line_irq}, exp_req(pl, en));
      rd(A_ST, {26'h0, pl});
      drive(6'h00);
      wr(A_ST, 32'h3f);
      rd(A_ST, {26'h0, pl});
      wr(A_ST, 32'h0);
      rd(A_ST, 32'h0);
      chk({26'h0, line_irq}, 32'h0);
    end
    $display("test level random done");
    // a held low line keeps its flag up against a clear
    drive(6'h01);
    wr(A_ST, 32'h0);
    rd(A_ST, 32'h01);
    // edge mode ignores a steady low, sets on a fall
    wr(A_SNS, 32'h3f);
    drive(6'h3f);
    wr(A_ST, 32'h0);
    rd(A_ST, 32'h0);
    drive(6'h00);
    rd(A_ST, 32'h0);
    drive(6'h2a);
    rd(A_ST, 32'h2a);
    drive(6'h00);
    $display("test edge done");
    // reset in mid-run with flags and modes dirty
    rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(A_ST, 32'h0);
    rd(A_EN, 32'h0);
    rd(A_SNS, 32'h0);
    // a write with lane 0 off is acked and ignored
    sel_v = 4'he;
    wr(A_EN, 32'h3f);
    sel_v = 4'hf;
    rd(A_EN, 32'h0);
    $display("test mid reset done");
    // summary interrupt: mask, set, read-clear
    wr(A_SNS, 32'h0);
    wr(A_ST, 32'h0);
    bus(1'b0, A_EV, 32'h0, q);
    wr(A_MSK, 32'h3f);
    drive(6'h04);
    chk({31'h0, irq}, 32'h1);
    rd(A_EV, 32'h04);
    @(posedge sys_clk);
    chk({31'h0, irq}, 32'h0);
    wr(A_MSK, 32'h0);
    drive(6'h00);
    wr(A_ST, 32'h0);
    drive(6'h08);
    chk({31'h0, irq}, 32'h0);
    rd(A_EV, 32'h08);
    $display("test interrupt done");
    complete_run();
  end
endmodule : tb_external_line_interrupt_unit

// ==== src/elu_line_detect.sv ====
// request condition detector for one external request line
module elu_line_detect
  import elu_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  // line and its mode
  input wire logic req_n_in,
  input wire logic edge_mode_in,
  // condition seen this cycle
  output logic set_out
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic prev;
  } elu_det_t;

  elu_det_t st;
  elu_det_t next_st;

  // level mode follows the pin, edge mode needs high then low
  always_comb begin
    next_st = st;
    next_st.prev = req_n_in;
    if (edge_mode_in == ELU_SENSE_EDGE) begin
      set_out = st.prev & ~req_n_in;
    end else begin
      set_out = ~req_n_in;
    end
  end

  // previous pin sample, idle high out of reset
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st.prev <= ELU_PIN_IDLE;
    end else begin
      st <= next_st;
    end
  end

endmodule : elu_line_detect

// ==== src/elu_pkg.sv ====
// constants for the external line interrupt unit
//
// Behaviour
// - sense 0: low level requests while low
// - sense 1: only falling edges request
// - enable bit 0 blocks, 1 passes line_irq_out only
// - level mode: low sample sets the flag
// - edge mode: high-to-low change sets flag
// - software only clears flags, by writing 0
// - enable and flag bits reset to 0
package elu_pkg;

  // -----------------------------------------------------------------
  // bus geometry
  // -----------------------------------------------------------------
  localparam int ELU_ADR_W = 24;
  localparam int ELU_DAT_W = 32;
  localparam int ELU_IDX_W = ELU_ADR_W - 2;
  localparam int ELU_LINES = 6;
  localparam int ELU_REG_W = 8;

  // -----------------------------------------------------------------
  // register indexes; the byte address is four times the index
  // -----------------------------------------------------------------
  localparam logic [ELU_IDX_W-1:0] ELU_IDX_SENSE = 22'h0ee014;
  localparam logic [ELU_IDX_W-1:0] ELU_IDX_ENABLE = 22'h0ee015;
  localparam logic [ELU_IDX_W-1:0] ELU_IDX_STATUS = 22'h0ee016;
  localparam logic [ELU_IDX_W-1:0] ELU_IDX_EVENT = 22'h0ee030;
  localparam logic [ELU_IDX_W-1:0] ELU_IDX_EVMASK = 22'h0ee031;

  // -----------------------------------------------------------------
  // field layout and reset values
  // -----------------------------------------------------------------
  localparam int ELU_LINE_LSB = 0;
  localparam int ELU_LINE_MSB = ELU_LINE_LSB + ELU_LINES - 1;
  localparam logic [ELU_LINES-1:0] ELU_SENSE_RST = 6'h00;
  localparam logic [ELU_LINES-1:0] ELU_ENABLE_RST = 6'h00;
  localparam logic [ELU_LINES-1:0] ELU_STATUS_RST = 6'h00;
  localparam logic [ELU_LINES-1:0] ELU_EVENT_RST = 6'h00;
  localparam logic [ELU_LINES-1:0] ELU_EVMASK_RST = 6'h00;
  localparam logic [ELU_DAT_W-1:0] ELU_DAT_RST = 32'h0000_0000;
  localparam logic ELU_PIN_IDLE = 1'b1;

  // sense selection codes
  localparam logic ELU_SENSE_LEVEL = 1'b0;
  localparam logic ELU_SENSE_EDGE = 1'b1;

  // -----------------------------------------------------------------
  // timing: bus answer follows the request by one cycle
  // -----------------------------------------------------------------
  localparam int ELU_ACK_LAT = 1;

endpackage : elu_pkg

// ==== src/elu_top.sv ====
// external line interrupt unit with a classic wishbone slave
module elu_top
  import elu_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  // wishbone slave
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [ELU_ADR_W-1:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [ELU_DAT_W-1:0] wb_dat_in,
  output logic [ELU_DAT_W-1:0] wb_dat_out,
  output logic wb_ack_out,
  // external request lines, active low
  input wire logic [ELU_LINES-1:0] line_req_n_in,
  // per-line requests to the cpu and summary interrupt
  output logic [ELU_LINES-1:0] line_irq_out,
  output logic irq_out
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [ELU_LINES-1:0] sense;
    logic [ELU_LINES-1:0] enable;
    logic [ELU_LINES-1:0] flags;
    logic [ELU_LINES-1:0] event_st;
    logic [ELU_LINES-1:0] event_mask;
    logic [ELU_LINES-1:0] line_irq;
    logic irq;
    logic ack;
    logic [ELU_DAT_W-1:0] dat;
  } elu_state_t;

  elu_state_t st;
  elu_state_t next_st;

  // ---------------------------------------------------------------
  // decode helpers
  // ---------------------------------------------------------------

  // true when the word address selects the given register index
  function automatic logic elu_hit(
    input logic [ELU_ADR_W-1:0] adr,
    input logic [ELU_IDX_W-1:0] idx
  );
    elu_hit = (adr[ELU_ADR_W-1:2] == idx);
  endfunction : elu_hit

  // zero-extend a line vector into a bus word
  function automatic logic [ELU_DAT_W-1:0] elu_word(
    input logic [ELU_LINES-1:0] v
  );
    elu_word = {{(ELU_DAT_W-ELU_LINES){1'b0}}, v};
  endfunction : elu_word

  // ---------------------------------------------------------------
  // line condition detectors
  // ---------------------------------------------------------------
  logic [ELU_LINES-1:0] set_vec;

  // one detector per external line, mode taken from the sense bits
  genvar gi;
  generate
    for (gi = 0; gi < ELU_LINES; gi = gi + 1) begin : g_line
      elu_line_detect u_det (
        .sys_clk_in(sys_clk_in),
        .rst_n_in(rst_n_in),
        .req_n_in(line_req_n_in[gi]),
        .edge_mode_in(st.sense[gi]),
        .set_out(set_vec[gi])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // bus qualifiers
  // ---------------------------------------------------------------
  logic bus_req;
  logic bus_done;
  logic bus_wr;
  logic bus_rd;
  logic lane0;
  logic hit_sense;
  logic hit_enable;
  logic hit_status;
  logic hit_event;
  logic hit_evmask;

  // the access commits at the edge where the master sees ack
  assign bus_req = wb_cyc_in & wb_stb_in;
  assign bus_done = bus_req & st.ack;
  assign bus_wr = bus_done & wb_we_in;
  assign bus_rd = bus_done & ~wb_we_in;
  assign lane0 = wb_sel_in[0];
  assign hit_sense = elu_hit(wb_adr_in, ELU_IDX_SENSE);
  assign hit_enable = elu_hit(wb_adr_in, ELU_IDX_ENABLE);
  assign hit_status = elu_hit(wb_adr_in, ELU_IDX_STATUS);
  assign hit_event = elu_hit(wb_adr_in, ELU_IDX_EVENT);
  assign hit_evmask = elu_hit(wb_adr_in, ELU_IDX_EVMASK);

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  logic [ELU_LINES-1:0] wr_bits;
  logic [ELU_LINES-1:0] flag_clr;
  logic [ELU_LINES-1:0] event_clr;

  always_comb begin
    next_st = st;
    wr_bits = wb_dat_in[ELU_LINE_MSB:ELU_LINE_LSB];
    flag_clr = '0;
    event_clr = '0;

    // ack one cycle after the request, dropped in the following one
    next_st.ack = bus_req & ~st.ack;

    // plain read/write control registers, low lane only
    if (bus_wr && lane0 && hit_sense) begin
      next_st.sense = wr_bits;
    end
    if (bus_wr && lane0 && hit_enable) begin
      next_st.enable = wr_bits;
    end
    if (bus_wr && lane0 && hit_evmask) begin
      next_st.event_mask = wr_bits;
    end

    // zeros written to the status register clear, ones keep
    if (bus_wr && lane0 && hit_status) begin
      flag_clr = ~wr_bits;
    end
    // reading the event register clears only the bits the read returned,
    // so an event landing while the access is open is not lost
    if (bus_rd && hit_event) begin
      event_clr = st.dat[ELU_LINE_MSB:ELU_LINE_LSB];
    end

    // a new condition wins over a clear in the same cycle
    next_st.flags = (st.flags & ~flag_clr) | set_vec;
    next_st.event_st = (st.event_st & ~event_clr) | (set_vec & ~st.flags);

    // per-line requests and summary level
    next_st.line_irq = next_st.flags & next_st.enable;
    next_st.irq = |(next_st.event_st & next_st.event_mask);

    // read data loaded together with ack, zero elsewhere
    next_st.dat = ELU_DAT_RST;
    if (bus_req && !st.ack && !wb_we_in) begin
      if (hit_sense) begin
        next_st.dat = elu_word(st.sense);
      end else if (hit_enable) begin
        next_st.dat = elu_word(st.enable);
      end else if (hit_status) begin
        next_st.dat = elu_word(st.flags);
      end else if (hit_event) begin
        next_st.dat = elu_word(st.event_st);
      end else if (hit_evmask) begin
        next_st.dat = elu_word(st.event_mask);
      end else begin
        next_st.dat = ELU_DAT_RST;
      end
    end
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st.sense <= ELU_SENSE_RST;
      st.enable <= ELU_ENABLE_RST;
      st.flags <= ELU_STATUS_RST;
      st.event_st <= ELU_EVENT_RST;
      st.event_mask <= ELU_EVMASK_RST;
      st.line_irq <= '0;
      st.irq <= 1'b0;
      st.ack <= 1'b0;
      st.dat <= ELU_DAT_RST;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from the state register
  assign wb_dat_out = st.dat;
  assign wb_ack_out = st.ack;
  assign line_irq_out = st.line_irq;
  assign irq_out = st.irq;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!rst_n_in);

  logic [ELU_LINES-1:0] lvl_hits;
  logic [ELU_LINES-1:0] keep_mask;
  logic [ELU_LINES-1:0] clr_mask;
  logic [ELU_LINES-1:0] flags_w;

  // helper vectors sampled by the checks below
  assign lvl_hits = ~line_req_n_in & ~st.sense;
  assign keep_mask = st.flags & wb_dat_in[ELU_LINE_MSB:ELU_LINE_LSB];
  assign clr_mask = ~wb_dat_in[ELU_LINE_MSB:ELU_LINE_LSB] & ~set_vec;
  assign flags_w = st.flags;

  logic [ELU_LINES-1:0] ev_new;
  logic [ELU_LINES-1:0] ev_w;
  logic [ELU_LINES-1:0] shown_ev;

  // event inputs and the event bits that a read has returned
  assign ev_new = set_vec & ~st.flags;
  assign ev_w = st.event_st;
  assign shown_ev = st.dat[ELU_LINE_MSB:ELU_LINE_LSB] & ~ev_new;

  // a committed write of the status register
  sequence s_status_write;
    bus_wr && lane0 && hit_status;
  endsequence

  // a request opening a bus cycle
  sequence s_bus_open;
    bus_req && !st.ack;
  endsequence

  // a committed read of the event register
  sequence s_event_read;
    bus_rd && hit_event;
  endsequence

  // a committed write with the low byte lane off
  sequence s_lane_off;
    bus_wr && !lane0;
  endsequence

  a_level_sets_flag: assert property (
    (lvl_hits != '0) |=> ((st.flags & $past(lvl_hits)) == $past(lvl_hits))
  ) else $error("low level line did not set its flag");

  generate
    for (gi = 0; gi < ELU_LINES; gi = gi + 1) begin : g_chk
      a_flag_rise_cause: assert property (
        $rose(st.flags[gi]) |->
          ($past(st.sense[gi]) ?
            ($past(line_req_n_in[gi], 2) && !$past(line_req_n_in[gi])) :
            !$past(line_req_n_in[gi]))
      ) else $error("flag rose without its sense condition");

      a_edge_sets_flag: assert property (
        (st.sense[gi] && $fell(line_req_n_in[gi])) |=> st.flags[gi]
      ) else $error("falling edge did not set its flag");
    end
  endgenerate

  a_enable_gates: assert property (
    ##1 (line_irq_out == (st.flags & st.enable))
  ) else $error("line request differs from flag and enable");

  a_write_one_keeps: assert property (
    s_status_write |=> ((st.flags & $past(keep_mask)) == $past(keep_mask))
  ) else $error("writing one changed a set flag");

  a_write_zero_clears: assert property (
    s_status_write |=> ((st.flags & $past(clr_mask)) == '0)
  ) else $error("writing zero left a flag set");

  a_no_soft_set: assert property (
    1'b1 |=> ((st.flags & ~$past(flags_w) & ~$past(set_vec)) == '0)
  ) else $error("flag set without a line condition");

  a_reset_clears: assert property (
    @(posedge sys_clk_in) disable iff (1'b0)
      !rst_n_in |-> (st.enable == '0 && st.flags == '0)
  ) else $error("enable or flags not zero in reset");

  a_bus_ack_pulse: assert property (
    s_bus_open |=> wb_ack_out ##1 !wb_ack_out
  ) else $error("ack was not a single cycle pulse");

  a_irq_level: assert property (
    ##1 (irq_out == |(st.event_st & st.event_mask))
  ) else $error("summary interrupt differs from masked events");

  a_event_read_clears: assert property (
    s_event_read |=> ((st.event_st & $past(shown_ev)) == '0)
  ) else $error("event read left a returned bit set");

  a_event_cause: assert property (
    1'b1 |=> ((st.event_st & ~$past(ev_w) & ~$past(ev_new)) == '0)
  ) else $error("event bit set without a flag rise");

  a_lane_off_ignored: assert property (
    s_lane_off |=> ($stable(st.enable) && $stable(st.sense))
  ) else $error("write with lane 0 off changed a register");

  a_idle_dat_zero: assert property (
    !wb_ack_out |-> (wb_dat_out == '0)
  ) else $error("read data not zero outside ack");

  a_reserved_zero: assert property (
    wb_dat_out[ELU_DAT_W-1:ELU_LINES] == '0
  ) else $error("reserved read data bits not zero");

endmodule : elu_top
